// ### logic/smc_top.sv
// Notes on behaviour
// - Low osc stop only if option allows
// - Running low osc keeps running in stop
// - Settle count starts after oscillation begins
// - Reset settle time comes from option
// - Pending unmasked interrupt blocks or ends standby
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ns
module smc_top
   import smc_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   input  wire logic [3:0]           addr,
   input  wire logic [7:0]           wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic      [7:0]           rdata,
   input  wire logic                 opt_low_osc_soft,
   input  wire logic [SMC_SEL_W-1:0] opt_settle_sel,
   input  wire logic                 cpu_halt_req,
   input  wire logic                 cpu_stop_req,
   input  wire logic                 osc_started,
   input  wire logic [SMC_IRQ_W-1:0] irq_flag,
   input  wire logic [SMC_IRQ_W-1:0] irq_mask,
   output logic                      cpu_clk_en,
   output logic                      main_osc_en,
   output logic                      low_osc_en,
   output logic                      standby_exit
);
   // =====================================================
   // Registers and state
   smc_state_e           state_ff;
   smc_state_e           nxt_state;
   logic                 low_osc_stop_request_ff;
   logic [SMC_SEL_W-1:0] osc_settle_select_ff;
   logic                 boot_ff;
   logic                 wake;
   logic                 settle_done;
   logic                 settle_load;
   logic [SMC_SEL_W-1:0] settle_sel;
   logic                 low_osc_run;

   smc_wake_detect u_wake (
      .irq_flag (irq_flag),
      .irq_mask (irq_mask),
      .wake     (wake)
   );

   smc_settle_cnt u_cnt (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .load    (settle_load),
      .sel     (settle_sel),
      .done    (settle_done)
   );

   // =====================================================
   // Register writes
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         low_osc_stop_request_ff <= 1'b0;
         osc_settle_select_ff    <= SMC_SETTLE_RST;
      end else if (wr) begin
         if (addr == SMC_ADDR_CTRL) begin
            low_osc_stop_request_ff <= wdata[SMC_BIT_LSTOP];
         end
         if (addr == SMC_ADDR_SETTLE) begin
            osc_settle_select_ff <= wdata[SMC_SEL_W-1:0];
         end
      end
   end

   // Boot wait pending after reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         boot_ff <= 1'b1;
      end else if (state_ff == SMC_WAIT && settle_done) begin
         boot_ff <= 1'b0;
      end
   end

   // Boot uses the option setting
   assign settle_sel = boot_ff ? opt_settle_sel : osc_settle_select_ff;

   // Count loads when oscillation has begun
   assign settle_load = (state_ff == SMC_START) && osc_started;

   // Request honoured only when option permits
   assign low_osc_run = !(low_osc_stop_request_ff && opt_low_osc_soft);

   // =====================================================
   // Standby sequencing
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SMC_RUN: begin
            if (!boot_ff) begin
               if (cpu_stop_req && !wake) begin
                  nxt_state = SMC_STOP;
               end else if (cpu_halt_req && !wake) begin
                  nxt_state = SMC_HALT;
               end
            end else begin
               nxt_state = SMC_START;
            end
         end
         SMC_HALT: begin
            if (wake) begin
               nxt_state = SMC_RUN;
            end
         end
         SMC_STOP: begin
            if (wake) begin
               nxt_state = SMC_START;
            end
         end
         SMC_START: begin
            if (osc_started) begin
               nxt_state = SMC_WAIT;
            end
         end
         SMC_WAIT: begin
            if (settle_done) begin
               nxt_state = SMC_RUN;
            end
         end
         default: nxt_state = SMC_RUN;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= SMC_START;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // =====================================================
   // Outputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cpu_clk_en   <= 1'b0;
         main_osc_en  <= 1'b1;
         standby_exit <= 1'b0;
      end else begin
         cpu_clk_en   <= (nxt_state == SMC_RUN);
         main_osc_en  <= (nxt_state != SMC_STOP);
         standby_exit <= (state_ff != SMC_RUN) && (nxt_state == SMC_RUN);
      end
   end

   // Low osc state frozen across stop
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         low_osc_en <= 1'b1;
      end else if (nxt_state != SMC_STOP || state_ff != SMC_STOP) begin
         if (state_ff == SMC_STOP || nxt_state == SMC_STOP) begin
            low_osc_en <= low_osc_en;
         end else begin
            low_osc_en <= low_osc_run;
         end
      end
   end

   // =====================================================
   // Read port
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            SMC_ADDR_CTRL:   rdata <= {7'h00, low_osc_stop_request_ff};
            SMC_ADDR_SETTLE: rdata <= {5'h00, osc_settle_select_ff};
            SMC_ADDR_STAT:   rdata <= {2'h0, low_osc_en, boot_ff, 4'(state_ff[4:1])};
            SMC_ADDR_INTR:   rdata <= irq_flag & ~irq_mask;
            default:         rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // =====================================================
   // Check helpers
   logic [SMC_CNT_W-1:0] chk_wait_ff;
   logic [SMC_CNT_W-1:0] chk_len_ff;

   // Settle length of one selection
   function automatic logic [SMC_CNT_W-1:0] chk_len(input logic [SMC_SEL_W-1:0] s);
      chk_len = SMC_CNT_W'(1) << (SMC_SEL_BASE + 4'(s));
   endfunction

   // Cycles spent in the wait since the load
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chk_wait_ff <= '0;
      end else if (settle_load) begin
         chk_wait_ff <= '0;
      end else if (state_ff == SMC_WAIT) begin
         chk_wait_ff <= chk_wait_ff + SMC_CNT_W'(1);
      end
   end

   // Length the wait should last
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chk_len_ff <= '0;
      end else if (settle_load && boot_ff) begin
         chk_len_ff <= chk_len(opt_settle_sel);
      end else if (settle_load) begin
         chk_len_ff <= chk_len(osc_settle_select_ff);
      end
   end

   // =====================================================
   // Standby checks
   a_stop_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff == SMC_RUN && wake) |=> state_ff != SMC_STOP && state_ff != SMC_HALT)
      else $error("standby entered with pending wake");
   a_stop_enter: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff == SMC_RUN && !boot_ff && cpu_stop_req && !wake) |=>
      state_ff == SMC_STOP && !cpu_clk_en && !main_osc_en)
      else $error("stop request not taken");
   a_halt_enter: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff == SMC_RUN && !boot_ff && cpu_halt_req && !cpu_stop_req && !wake) |=>
      state_ff == SMC_HALT && !cpu_clk_en && main_osc_en)
      else $error("halt request not taken");
   a_halt_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff == SMC_HALT && wake) |=> state_ff == SMC_RUN ##1 cpu_clk_en)
      else $error("halt not left on wake");
   a_stop_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff == SMC_STOP && wake) |=> state_ff == SMC_START)
      else $error("stop not left on wake");
   a_boot_no_standby: assert property (@(posedge clk_sys) disable iff (!rst_n)
      boot_ff |-> state_ff != SMC_STOP && state_ff != SMC_HALT)
      else $error("standby entered during boot wait");

   // =====================================================
   // Clock and settle checks
   a_no_count_early: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff == SMC_START && !osc_started) |=> state_ff == SMC_START)
      else $error("wait began before oscillation");
   a_clk_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff == SMC_WAIT && !settle_done) |=> !cpu_clk_en)
      else $error("cpu clock ran during wait");
   a_clk_resume: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff == SMC_WAIT && settle_done) |=> cpu_clk_en && standby_exit)
      else $error("cpu clock not resumed");
   a_clk_tracks: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cpu_clk_en == (state_ff == SMC_RUN))
      else $error("cpu clock outside run");
   a_exit_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
      standby_exit |=> !standby_exit)
      else $error("exit pulse longer than one cycle");
   a_boot_option: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff == SMC_WAIT && settle_done && boot_ff) |->
      chk_wait_ff == chk_len_ff - SMC_CNT_W'(1))
      else $error("boot wait not from option");
   a_settle_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff == SMC_WAIT && settle_done && !boot_ff) |->
      chk_wait_ff == chk_len_ff - SMC_CNT_W'(1))
      else $error("stop wait length wrong");
   a_settle_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state_ff == SMC_WAIT |-> chk_wait_ff < chk_len_ff)
      else $error("wait ran past its length");

   // =====================================================
   // Oscillator and port checks
   a_low_osc_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff == SMC_STOP && $past(state_ff) == SMC_STOP) |-> $stable(low_osc_en))
      else $error("low osc changed in stop");
   a_low_osc_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff != SMC_STOP && nxt_state == SMC_STOP) |=> $stable(low_osc_en))
      else $error("low osc changed on stop entry");
   a_low_osc_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!opt_low_osc_soft && state_ff == SMC_RUN && $past(state_ff) == SMC_RUN) ##1
      state_ff == SMC_RUN |-> low_osc_en)
      else $error("low osc stopped while locked");
   a_low_osc_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff != SMC_STOP && nxt_state != SMC_STOP) |=> low_osc_en == $past(low_osc_run))
      else $error("low osc not following request");
   a_main_osc_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
      main_osc_en == (state_ff != SMC_STOP))
      else $error("main osc state wrong");
   a_main_osc_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_ff == SMC_STOP && wake) |=> main_osc_en)
      else $error("main osc not restarted on wake");
   a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !rd |=> rdata == '0)
      else $error("read data without read");

   // =====================================================
   // Covers
   c_stop_cycle: cover property (@(posedge clk_sys) disable iff (!rst_n)
      state_ff == SMC_STOP ##[1:50] state_ff == SMC_WAIT);
   c_halt_cycle: cover property (@(posedge clk_sys) disable iff (!rst_n)
      state_ff == SMC_HALT ##[1:50] state_ff == SMC_RUN);
   c_boot_done: cover property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(boot_ff));
   c_stop_refused: cover property (@(posedge clk_sys) disable iff (!rst_n)
      state_ff == SMC_RUN && !boot_ff && cpu_stop_req && wake);
   c_low_osc_frozen: cover property (@(posedge clk_sys) disable iff (!rst_n)
      state_ff == SMC_STOP && low_osc_en && !low_osc_run);
endmodule

// ### logic/smc_pkg.sv
package smc_pkg;
   // =====================================================
   // Register map
   localparam logic [3:0] SMC_ADDR_CTRL   = 4'h0;
   localparam logic [3:0] SMC_ADDR_SETTLE = 4'h1;
   localparam logic [3:0] SMC_ADDR_STAT   = 4'h2;
   localparam logic [3:0] SMC_ADDR_INTR   = 4'h3;
   localparam int         SMC_BIT_LSTOP   = 0;
   localparam int         SMC_STAT_W      = 6;
   // =====================================================
   // Settle selections and reset values
   localparam int         SMC_SEL_W       = 3;
   localparam int         SMC_CNT_W       = 16;
   localparam logic [2:0] SMC_SETTLE_RST  = 3'h4;
   localparam logic [3:0] SMC_SEL_BASE    = 4'h4;
   localparam int         SMC_START_NS    = 64;
   localparam int         SMC_CLK_NS      = 8;
   localparam logic [7:0] SMC_START_CYC   =
      8'((SMC_START_NS + SMC_CLK_NS - 1) / SMC_CLK_NS);
   localparam int         SMC_IRQ_W       = 8;
   // =====================================================
   // States
   typedef enum logic [4:0] {
      SMC_RUN   = 5'h01,
      SMC_HALT  = 5'h02,
      SMC_STOP  = 5'h04,
      SMC_START = 5'h08,
      SMC_WAIT  = 5'h10
   } smc_state_e;
endpackage

// ### logic/smc_settle_cnt.sv
`timescale 1ns/1ns
module smc_settle_cnt
   import smc_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   input  wire logic                 load,
   input  wire logic [SMC_SEL_W-1:0] sel,
   output logic                      done
);
   logic [SMC_CNT_W-1:0] cnt_ff;

   // Lengths are 2^(sel+4) cycles
   function automatic logic [SMC_CNT_W-1:0] sel_len(input logic [SMC_SEL_W-1:0] s);
      sel_len = SMC_CNT_W'(1) << (SMC_SEL_BASE + 4'(s));
   endfunction

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else if (load) begin
         cnt_ff <= sel_len(sel);
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - SMC_CNT_W'(1);
      end
   end

   assign done = (cnt_ff == SMC_CNT_W'(1)) && !load;
endmodule

// ### logic/smc_wake_detect.sv
`timescale 1ns/1ns
module smc_wake_detect
   import smc_pkg::*;
(
   input  wire logic [SMC_IRQ_W-1:0] irq_flag,
   input  wire logic [SMC_IRQ_W-1:0] irq_mask,
   output logic                      wake
);
   // Any set request with clear mask
   assign wake = |(irq_flag & ~irq_mask);
endmodule

// ### sim/smc_core_model.sv
`timescale 1ns/1ns
// ==========
// CPU core and main oscillator model
module smc_core_model
   import smc_pkg::*;
#(
   parameter int START_DLY = 40
)(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic main_osc_en,
   output logic      osc_started,
   output logic      cpu_halt_req,
   output logic      cpu_stop_req
);
   int   cnt;
   logic periph_run;
   initial begin
      cpu_halt_req = 1'b0;
      cpu_stop_req = 1'b0;
      periph_run   = 1'b1;
   end
   // Oscillation begins some cycles after the enable
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n || !main_osc_en) begin
         cnt         <= 0;
         osc_started <= 1'b0;
      end else if (cnt < START_DLY) begin
         cnt <= cnt + 1;
      end else begin
         osc_started <= 1'b1;
      end
   end
   // One standby instruction, stop or halt
   task automatic standby(input logic stop);
      @(posedge clk_sys);
      periph_run   <= ~stop;
      @(posedge clk_sys);
      cpu_stop_req <= stop & ~periph_run;
      cpu_halt_req <= ~stop;
      @(posedge clk_sys);
      cpu_stop_req <= 1'b0;
      cpu_halt_req <= 1'b0;
   endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %s exp %0h got %0h", nm, e, g); end end
// ==========
// Bench
module tb;
   import smc_pkg::*;
   logic       clk_sys, rst_n, wr, rd, opt_low_osc_soft, osc_started;
   logic       cpu_halt_req, cpu_stop_req, cpu_clk_en, main_osc_en, low_osc_en, standby_exit;
   logic [3:0] addr;
   logic [2:0] opt_settle_sel;
   logic [7:0] wdata, rdata, irq_flag, irq_mask;
   int         error_cnt = 0;
   int         n_checks = 0;
   int         cyc = 0;
   smc_top u_dut(.clk_sys, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .opt_low_osc_soft,
      .opt_settle_sel, .cpu_halt_req, .cpu_stop_req, .osc_started, .irq_flag, .irq_mask,
      .cpu_clk_en, .main_osc_en, .low_osc_en, .standby_exit);
   smc_core_model u_core(.clk_sys, .rst_n, .main_osc_en, .osc_started, .cpu_halt_req,
      .cpu_stop_req);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_sys);
      wr    <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, input logic [7:0] e, input string nm);
      @(posedge clk_sys);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_sys);
      rd   <= 1'b0;
      #1;
      `CHK(nm, e, rdata)
   endtask
   // Settle length from oscillation start to CPU clock
   task automatic settle_chk(input int l);
      int n;
      n = 0;
      while (osc_started !== 1'b1 && n < 500) begin
         tick(1);
         n++;
      end
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      `CHK("settle_len", 1'b1, n >= l && n <= l + 4)
   endtask
   task automatic t_regs();
      bus_rd(SMC_ADDR_SETTLE, 8'h04, "settle_rst");
      bus_rd(SMC_ADDR_CTRL, 8'h00, "ctrl_rst");
      bus_rd(SMC_ADDR_STAT, 8'h20, "stat_run");
      bus_wr(SMC_ADDR_SETTLE, 8'h01);
      bus_rd(SMC_ADDR_SETTLE, 8'h01, "settle_rw");
      bus_rd(4'h9, 8'h00, "unmapped");
      @(posedge clk_sys);
      irq_flag <= 8'h05;
      irq_mask <= 8'hfe;
      bus_rd(SMC_ADDR_INTR, 8'h01, "intr");
      @(posedge clk_sys);
      irq_flag <= 8'h00;
   endtask
   task automatic t_lowosc();
      bus_wr(SMC_ADDR_CTRL, 8'h01);
      tick(2);
      `CHK("low_osc_kept", 1'b1, low_osc_en)
      @(posedge clk_sys);
      opt_low_osc_soft <= 1'b1;
      tick(2);
      `CHK("low_osc_off", 1'b0, low_osc_en)
      bus_wr(SMC_ADDR_CTRL, 8'h00);
      tick(2);
      `CHK("low_osc_on", 1'b1, low_osc_en)
   endtask
   task automatic t_stop();
      u_core.standby(1'b1);
      tick(2);
      `CHK("stop_clk", 1'b0, cpu_clk_en)
      `CHK("stop_osc", 1'b0, main_osc_en)
      bus_wr(SMC_ADDR_CTRL, 8'h01);
      tick(20);
      `CHK("stop_low_osc", 1'b1, low_osc_en)
      bus_rd(SMC_ADDR_STAT, 8'h22, "stat_stop");
      @(posedge clk_sys);
      irq_flag <= 8'h02;
      irq_mask <= 8'h00;
      settle_chk(32);
      `CHK("exit_pulse", 1'b1, standby_exit)
      tick(1);
      `CHK("exit_end", 1'b0, standby_exit)
      `CHK("low_osc_woke", 1'b0, low_osc_en)
      bus_wr(SMC_ADDR_CTRL, 8'h00);
      irq_flag <= 8'h00;
   endtask
   task automatic t_block();
      @(posedge clk_sys);
      irq_flag <= 8'h10;
      u_core.standby(1'b1);
      tick(3);
      `CHK("stop_refused", 1'b1, cpu_clk_en)
      `CHK("osc_kept", 1'b1, main_osc_en)
      @(posedge clk_sys);
      irq_mask <= 8'h10;
      u_core.standby(1'b0);
      tick(3);
      `CHK("halt_clk", 1'b0, cpu_clk_en)
      @(posedge clk_sys);
      irq_mask <= 8'h00;
      tick(4);
      `CHK("halt_wake", 1'b1, cpu_clk_en)
      @(posedge clk_sys);
      irq_flag <= 8'h00;
   endtask
   initial begin
      rst_n = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      opt_low_osc_soft = 1'b0;
      opt_settle_sel = 3'h0;
      irq_flag = 8'h00;
      irq_mask = 8'hff;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      settle_chk(16);
      t_regs();
      t_lowosc();
      t_stop();
      t_block();
      tally_and_finish();
   end
endmodule
